// >>> atb_consts.svh
// Purpose: constants of the asynchronous timer bridge
// Assumes: plain register port, 8-bit data, 3-bit index
// Notes:   offsets are register indices
`ifndef ATB_CONSTS_SVH
`define ATB_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ATB_OFF_CONTROL  3'h0
`define ATB_OFF_COMPARE  3'h1
`define ATB_OFF_COUNTER  3'h2
`define ATB_OFF_STATUS   3'h3
`define ATB_OFF_MASK     3'h4
`define ATB_OFF_FLAGS    3'h5

// ----------------------------------------
// field positions
// ----------------------------------------
`define ATB_BIT_ASYNC_SEL   3
`define ATB_BIT_CNT_BUSY    2
`define ATB_BIT_CMP_BUSY    1
`define ATB_BIT_CTL_BUSY    0
`define ATB_BIT_CMP_IRQ     7
`define ATB_BIT_OVF_IRQ     6
`define ATB_CTL_COM_HI      5
`define ATB_CTL_COM_LO      4
`define ATB_CTL_CS_HI       2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define ATB_RST_BYTE        8'h00
`define ATB_FLAG_SYNC_CYC   3
`define ATB_MAX_COUNT       8'hff

`endif

// >>> atb_pkg.sv
// Purpose: types of the asynchronous timer bridge
// Assumes: nothing
// Notes:   channel index equals the busy bit position
package atb_pkg;

    // holding register progress, gray along idle -> one edge -> commit
    typedef enum logic [1:0] {
        ATB_HOLD_IDLE  = 2'b00,
        ATB_HOLD_WAIT1 = 2'b01,
        ATB_HOLD_WAIT2 = 2'b11
    } atb_hold_t;

    typedef logic [7:0] atb_byte_t;

endpackage

// >>> atb_timer_bridge.sv
// Purpose: register bridge between CPU port and crystal-clocked 8-bit timer
// Assumes: crystal pin sampled on sys_clk, sys_clk above four times crystal
// Notes:   all logic on sys_clk; crystal edges found by synchronised detect
//
// Local design decisions: the strobed register port and the register addresses.
`include "atb_consts.svh"

// What this block does
// - async select picks crystal or I/O clock
// - counter write sets busy until committed
// - compare write sets busy until committed
// - control write sets busy until committed
// - counter reads its copy, control and compare read holding
// - commit after two crystal rising edges
// - independent holding register for counter, compare and control
// - no compare match while counter or compare writes pending
// - interrupt flags clear one sys_clk cycle after ack or write
// - oscillator runs in async mode except deep sleep modes
// - wake-up starts on next timer tick
// - counter read copy refreshed each timer tick
// - flag sync three cycles plus timer cycle
// - compare pin changes on timer tick
// - irq requested from enable, global, flag
// - flags cleared by vector or writing one
module atb_timer_bridge
    import atb_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       crystal_clock_pin,
    input  wire logic       global_irq_enable,
    input  wire logic       compare_irq_ack,
    input  wire logic       overflow_irq_ack,
    input  wire logic       sleep_active,
    input  wire logic       deep_sleep,
    output logic            compare_irq_req,
    output logic            overflow_irq_req,
    output logic            compare_out,
    output logic            wake_req,
    output logic            osc_enable
);

    function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] off);
        return a == off;
    endfunction

    // ----------------------------------------
    // crystal edge detection
    // ----------------------------------------
    logic [2:0] xtal_sync_reg;
    logic       xtal_rise;
    logic       async_sel_reg;
    logic       tick;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            xtal_sync_reg <= 3'h0;
        end else begin
            xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_clock_pin};
        end
    end

    assign xtal_rise = xtal_sync_reg[1] & ~xtal_sync_reg[2];
    assign tick      = async_sel_reg ? xtal_rise : 1'b1;

    // ----------------------------------------
    // async select and oscillator enable
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            async_sel_reg <= 1'b0;
            osc_enable    <= 1'b0;
        end else begin
            if (reg_wr && wr_hit(reg_addr, `ATB_OFF_STATUS)) begin
                async_sel_reg <= reg_wdata[`ATB_BIT_ASYNC_SEL];
            end
            osc_enable <= async_sel_reg & ~deep_sleep;
        end
    end

    // ----------------------------------------
    // holding registers, one per channel
    // ----------------------------------------
    localparam logic [2:0] CH_OFF [3] = '{`ATB_OFF_COUNTER, `ATB_OFF_COMPARE,
                                          `ATB_OFF_CONTROL};
    atb_hold_t  hold_st_reg  [3];
    atb_byte_t  hold_val_reg [3];
    logic [2:0] busy;
    logic [2:0] commit;

    for (genvar ch = 0; ch < 3; ch++) begin : g_hold
        // CH_OFF is listed high index first
        logic hit;
        assign hit        = reg_wr && wr_hit(reg_addr, CH_OFF[2 - ch]);
        assign busy[ch]   = hold_st_reg[ch] != ATB_HOLD_IDLE;
        assign commit[ch] = (hold_st_reg[ch] == ATB_HOLD_WAIT2) && xtal_rise;

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                hold_val_reg[ch] <= `ATB_RST_BYTE;
            end else if (hit) begin
                hold_val_reg[ch] <= reg_wdata;
            end
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                hold_st_reg[ch] <= ATB_HOLD_IDLE;
            end else if (hit && async_sel_reg) begin
                hold_st_reg[ch] <= ATB_HOLD_WAIT1;
            end else if (!async_sel_reg) begin
                hold_st_reg[ch] <= ATB_HOLD_IDLE;
            end else if (xtal_rise) begin
                unique case (hold_st_reg[ch])
                    ATB_HOLD_IDLE:  hold_st_reg[ch] <= ATB_HOLD_IDLE;
                    ATB_HOLD_WAIT1: hold_st_reg[ch] <= ATB_HOLD_WAIT2;
                    ATB_HOLD_WAIT2: hold_st_reg[ch] <= ATB_HOLD_IDLE;
                    default:        hold_st_reg[ch] <= ATB_HOLD_IDLE;
                endcase
            end
        end
    end

    // sync mode writes land next cycle
    logic [2:0] sync_wr;
    assign sync_wr[0] = reg_wr && !async_sel_reg && wr_hit(reg_addr, `ATB_OFF_CONTROL);
    assign sync_wr[1] = reg_wr && !async_sel_reg && wr_hit(reg_addr, `ATB_OFF_COMPARE);
    assign sync_wr[2] = reg_wr && !async_sel_reg && wr_hit(reg_addr, `ATB_OFF_COUNTER);

    // ----------------------------------------
    // timer core
    // ----------------------------------------
    atb_byte_t control_reg;
    atb_byte_t compare_reg;
    atb_byte_t counter_reg;
    atb_byte_t cnt_copy_reg;
    logic      running;
    logic      match;
    logic      cmp_evt_reg;
    logic      ovf_evt_reg;

    assign running = control_reg[`ATB_CTL_CS_HI:0] != 3'h0;
    assign match   = running && (counter_reg == compare_reg) && !busy[1] && !busy[2];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control_reg <= `ATB_RST_BYTE;
            compare_reg <= `ATB_RST_BYTE;
        end else begin
            if (commit[0] || sync_wr[0]) begin
                control_reg <= commit[0] ? hold_val_reg[0] : reg_wdata;
            end
            if (commit[1] || sync_wr[1]) begin
                compare_reg <= commit[1] ? hold_val_reg[1] : reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            counter_reg <= `ATB_RST_BYTE;
            cmp_evt_reg <= 1'b0;
            ovf_evt_reg <= 1'b0;
        end else begin
            cmp_evt_reg <= tick && match;
            ovf_evt_reg <= tick && running && counter_reg == `ATB_MAX_COUNT;
            if (commit[2] || sync_wr[2]) begin
                counter_reg <= commit[2] ? hold_val_reg[2] : reg_wdata;
            end else if (tick && running) begin
                counter_reg <= counter_reg + 8'h01;
            end
        end
    end

    // pin follows timer tick directly, no CPU-side sync
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compare_out <= 1'b0;
        end else if (tick && match) begin
            unique case (control_reg[`ATB_CTL_COM_HI:`ATB_CTL_COM_LO])
                2'h0: compare_out <= compare_out;
                2'h1: compare_out <= ~compare_out;
                2'h2: compare_out <= 1'b0;
                2'h3: compare_out <= 1'b1;
            endcase
        end
    end

    // read copy refreshed on timer edges only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_copy_reg <= `ATB_RST_BYTE;
        end else if (tick) begin
            cnt_copy_reg <= counter_reg;
        end
    end

    // ----------------------------------------
    // interrupt flags and mask
    // ----------------------------------------
    logic [`ATB_FLAG_SYNC_CYC-1:0] cmp_dly_reg;
    logic [`ATB_FLAG_SYNC_CYC-1:0] ovf_dly_reg;
    logic      cmp_set;
    logic      ovf_set;
    logic      cmp_clr;
    logic      ovf_clr;
    logic      flag_wr;
    atb_byte_t mask_reg;
    logic      cmp_flag_reg;
    logic      ovf_flag_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmp_dly_reg <= '0;
            ovf_dly_reg <= '0;
        end else begin
            cmp_dly_reg <= {cmp_dly_reg[`ATB_FLAG_SYNC_CYC-2:0], cmp_evt_reg};
            ovf_dly_reg <= {ovf_dly_reg[`ATB_FLAG_SYNC_CYC-2:0], ovf_evt_reg};
        end
    end

    assign flag_wr = reg_wr && wr_hit(reg_addr, `ATB_OFF_FLAGS);
    assign cmp_set = async_sel_reg ? cmp_dly_reg[`ATB_FLAG_SYNC_CYC-1] : cmp_evt_reg;
    assign ovf_set = async_sel_reg ? ovf_dly_reg[`ATB_FLAG_SYNC_CYC-1] : ovf_evt_reg;
    assign cmp_clr = compare_irq_ack || (flag_wr && reg_wdata[`ATB_BIT_CMP_IRQ]);
    assign ovf_clr = overflow_irq_ack || (flag_wr && reg_wdata[`ATB_BIT_OVF_IRQ]);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmp_flag_reg <= 1'b0;
            ovf_flag_reg <= 1'b0;
        end else begin
            cmp_flag_reg <= cmp_set | (cmp_flag_reg & ~cmp_clr);
            ovf_flag_reg <= ovf_set | (ovf_flag_reg & ~ovf_clr);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_reg <= `ATB_RST_BYTE;
        end else if (reg_wr && wr_hit(reg_addr, `ATB_OFF_MASK)) begin
            mask_reg <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compare_irq_req  <= 1'b0;
            overflow_irq_req <= 1'b0;
        end else begin
            compare_irq_req  <= global_irq_enable & mask_reg[`ATB_BIT_CMP_IRQ]
                                & cmp_flag_reg;
            overflow_irq_req <= global_irq_enable & mask_reg[`ATB_BIT_OVF_IRQ]
                                & ovf_flag_reg;
        end
    end

    // ----------------------------------------
    // wake-up request
    // ----------------------------------------
    logic irq_pending;
    assign irq_pending = (mask_reg[`ATB_BIT_CMP_IRQ] & cmp_flag_reg)
                       | (mask_reg[`ATB_BIT_OVF_IRQ] & ovf_flag_reg);

    // wake raised on next tick; released only on a tick after sleep ends
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_req <= 1'b0;
        end else if (tick) begin
            wake_req <= sleep_active ? (wake_req | irq_pending) : 1'b0;
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `ATB_RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ATB_OFF_CONTROL: reg_rdata <= hold_val_reg[0];
                `ATB_OFF_COMPARE: reg_rdata <= hold_val_reg[1];
                `ATB_OFF_COUNTER: reg_rdata <= cnt_copy_reg;
                `ATB_OFF_STATUS:  reg_rdata <= {4'h0, async_sel_reg, busy};
                `ATB_OFF_MASK:    reg_rdata <= mask_reg;
                `ATB_OFF_FLAGS:   reg_rdata <= {cmp_flag_reg, ovf_flag_reg, 6'h00};
                default:          reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_CNT_BUSY_SET: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && async_sel_reg && reg_addr == `ATB_OFF_COUNTER |=> busy[2])
        else $error("counter write did not set busy");
    AST_CMP_BUSY_SET: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && async_sel_reg && reg_addr == `ATB_OFF_COMPARE |=> busy[1])
        else $error("compare write did not set busy");
    AST_CTL_BUSY_SET: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && async_sel_reg && reg_addr == `ATB_OFF_CONTROL |=> busy[0])
        else $error("control write did not set busy");
    AST_COMMIT_VALUE: assert property (@(posedge sys_clk) disable iff (rst)
        commit[1] |=> compare_reg == $past(hold_val_reg[1]) && !busy[1])
        else $error("compare commit wrong");
    AST_NO_MATCH_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
        (busy[1] || busy[2]) |=> !cmp_evt_reg)
        else $error("compare event while write pending");
    AST_FLAG_DELAY: assert property (@(posedge sys_clk) disable iff (rst)
        cmp_evt_reg && async_sel_reg ##1 async_sel_reg [*3] |=> cmp_flag_reg)
        else $error("compare flag not set after sync delay");
    AST_IRQ_REQ: assert property (@(posedge sys_clk) disable iff (rst)
        global_irq_enable && mask_reg[7] && cmp_flag_reg |=> compare_irq_req)
        else $error("compare irq not requested");
    AST_FLAG_W1C: assert property (@(posedge sys_clk) disable iff (rst)
        flag_wr && reg_wdata[6] && !ovf_set |=> !ovf_flag_reg)
        else $error("overflow flag not cleared");
    AST_COPY_STEADY: assert property (@(posedge sys_clk) disable iff (rst)
        !tick |=> $stable(cnt_copy_reg))
        else $error("read copy changed without tick");
    AST_OSC_ON: assert property (@(posedge sys_clk) disable iff (rst)
        async_sel_reg && !deep_sleep |=> osc_enable)
        else $error("oscillator off in async mode");

endmodule // atb_timer_bridge

// >>> atb_crystal_model.sv
// Purpose: watch crystal seen at the crystal clock pin
// Assumes: period well above four sys_clk cycles
// Notes:   pin stands low while the oscillator is disabled
module atb_crystal_model (
    input  wire logic osc_enable,
    input  wire logic slow,
    output logic      crystal_clock_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        crystal_clock_pin = 1'b0;
        #3;
        forever begin
            if (osc_enable) begin
                #(slow ? 76 : 44);
                crystal_clock_pin = ~crystal_clock_pin;
            end else begin
                crystal_clock_pin = 1'b0;
                @(osc_enable);
            end
        end
    end
endmodule // atb_crystal_model

// >>> atb_timer_bridge_tb.sv
// Purpose: self-checking bench of the timer bridge
// Assumes: crystal model drives the crystal clock pin
// Notes:   control and compare holding registers mirrored in a small model array
`include "atb_consts.svh"
module atb_timer_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import atb_pkg::*;

    logic       sys_clk, rst, reg_wr, reg_rd, slow, crystal_clock_pin;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       global_irq_enable, compare_irq_ack, overflow_irq_ack;
    logic       sleep_active, deep_sleep, compare_irq_req, overflow_irq_req;
    logic       compare_out, wake_req, osc_enable, o0;
    int         bad_count, check_count, cyc, seed, i, k;
    int         mdl [8];
    atb_byte_t  rv, c0;

    atb_timer_bridge i_atb_timer_bridge (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .crystal_clock_pin(crystal_clock_pin), .global_irq_enable(global_irq_enable),
        .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
        .sleep_active(sleep_active), .deep_sleep(deep_sleep),
        .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
        .compare_out(compare_out), .wake_req(wake_req), .osc_enable(osc_enable));
    atb_crystal_model i_atb_crystal_model (.osc_enable(osc_enable), .slow(slow),
        .crystal_clock_pin(crystal_clock_pin));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        if (a < 3'h2) mdl[a] = d;
    endtask
    task automatic rd(input logic [2:0] a, output atb_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 87;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        slow = 1'b1;
        global_irq_enable = 1'b0;
        compare_irq_ack = 1'b0;
        overflow_irq_ack = 1'b0;
        sleep_active = 1'b0;
        deep_sleep = 1'b0;
        foreach (mdl[j]) mdl[j] = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 3; i < 8; i++) begin
            rd(i[2:0], rv);
            chk(rv, 8'h00);
        end
        wr(3'h6, 8'h5a);
        rd(3'h6, rv);
        chk(rv, 8'h00);
        // sync mode: readback of holding registers, never busy
        for (i = 0; i < 8; i++) begin
            k = i % 2;
            wr(k[2:0], 8'($random(seed)));
            rd(k[2:0], rv);
            chk(rv, 8'(mdl[k]));
            rd(`ATB_OFF_STATUS, rv);
            chk(rv, 8'h00);
        end
        wr(`ATB_OFF_CONTROL, 8'h00);
        wr(`ATB_OFF_FLAGS, 8'hc0);
        wr(`ATB_OFF_STATUS, 8'h08);
        repeat (2) @(posedge sys_clk);
        chk({7'h0, osc_enable}, 8'h01);
        rd(`ATB_OFF_STATUS, rv);
        chk(rv, 8'h08);
        // three pending writes, each with its own holding register
        @(posedge crystal_clock_pin);
        repeat (3) @(posedge sys_clk);
        wr(`ATB_OFF_COUNTER, 8'hfe);
        wr(`ATB_OFF_COMPARE, 8'h10);
        wr(`ATB_OFF_CONTROL, 8'h11);
        rd(`ATB_OFF_STATUS, rv);
        chk(rv, 8'h0f);
        rd(`ATB_OFF_COMPARE, rv);
        chk(rv, 8'(mdl[1]));
        rd(`ATB_OFF_CONTROL, rv);
        chk(rv, 8'(mdl[0]));
        @(posedge crystal_clock_pin);
        repeat (4) @(posedge sys_clk);
        rd(`ATB_OFF_STATUS, rv);
        chk(rv, 8'h0f);
        @(posedge crystal_clock_pin);
        repeat (6) @(posedge sys_clk);
        rd(`ATB_OFF_STATUS, rv);
        chk(rv, 8'h08);
        // compare rewrite, then poll status until busy clears
        wr(`ATB_OFF_COMPARE, 8'h10);
        rd(`ATB_OFF_STATUS, rv);
        for (k = 0; k < 60 && rv !== 8'h08; k++) rd(`ATB_OFF_STATUS, rv);
        chk(rv, 8'h08);
        // counter read copy follows crystal ticks
        @(posedge crystal_clock_pin);
        repeat (5) @(posedge sys_clk);
        rd(`ATB_OFF_COUNTER, c0);
        repeat (3) @(posedge crystal_clock_pin);
        repeat (5) @(posedge sys_clk);
        rd(`ATB_OFF_COUNTER, rv);
        chk(rv, 8'(c0 + 8'h03));
        // overflow interrupt, masking and wake-up
        wr(`ATB_OFF_FLAGS, 8'hc0);
        wr(`ATB_OFF_MASK, 8'hc0);
        rd(`ATB_OFF_MASK, rv);
        chk(rv, 8'hc0);
        @(posedge sys_clk);
        global_irq_enable <= 1'b1;
        for (k = 0; k < 6000 && overflow_irq_req !== 1'b1; k++) @(posedge sys_clk);
        chk({7'h0, overflow_irq_req}, 8'h01);
        rd(`ATB_OFF_FLAGS, rv);
        chk(rv & 8'h40, 8'h40);
        global_irq_enable <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({7'h0, overflow_irq_req}, 8'h00);
        global_irq_enable <= 1'b1;
        sleep_active <= 1'b1;
        for (k = 0; k < 60 && wake_req !== 1'b1; k++) @(posedge sys_clk);
        chk({7'h0, wake_req}, 8'h01);
        sleep_active <= 1'b0;
        for (k = 0; k < 60 && wake_req !== 1'b0; k++) @(posedge sys_clk);
        chk({7'h0, wake_req}, 8'h00);
        wr(`ATB_OFF_FLAGS, 8'h40);
        repeat (2) @(posedge sys_clk);
        chk({7'h0, overflow_irq_req}, 8'h00);
        // compare match toggles the pin, ack clears the flag
        for (k = 0; k < 6000 && compare_irq_req !== 1'b1; k++) @(posedge sys_clk);
        chk({7'h0, compare_irq_req}, 8'h01);
        o0 = compare_out;
        compare_irq_ack <= 1'b1;
        @(posedge sys_clk);
        compare_irq_ack <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({7'h0, compare_irq_req}, 8'h00);
        for (k = 0; k < 6000 && compare_irq_req !== 1'b1; k++) @(posedge sys_clk);
        chk({7'h0, compare_out}, {7'h0, ~o0});
        // deep sleep and leaving async mode stop the oscillator
        deep_sleep <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({7'h0, osc_enable}, 8'h00);
        deep_sleep <= 1'b0;
        wr(`ATB_OFF_STATUS, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk({7'h0, osc_enable}, 8'h00);
        // control register rewritten after select change and deep sleep
        wr(`ATB_OFF_CONTROL, 8'h00);
        rd(`ATB_OFF_CONTROL, rv);
        chk(rv, 8'(mdl[0]));
        complete_run();
    end
endmodule // atb_timer_bridge_tb
